// ### rtl/acr_config_regs.sv
// Configuration register bank of a three-channel simultaneous-sampling ADC.
// Assumes the serial front end hands over decoded register requests on REF_CLK.
// Notes on behaviour
// - channel 2 gain is two to the power of its 3-bit code.
// - channel 1 gain is two to the power of its 3-bit code.
// - channel 0 gain is two to the power of its 3-bit code.
// - enable bit turns channel 2 positive input into a digital output.
// - while enabled, the pin follows the output value bit.
// - with chop on, wait two to the power code+1 clocks before measuring.
// - channel 0 sampling delayed by a signed 10-bit cycle count.
// - channel 0 input selector picks external, shorted, DC or AC diagnostic.
// - offset bits 23 to 8 come from the upper offset word.
// - offset bits 7 to 0 come from lower word's top byte; low byte reads zero.
`timescale 1ns/100ps
`include "acr_map.svh"
module acr_config_regs
  import acr_pkg::*;
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Register request from the serial interface.
  input wire acr_req_t REQ,
  // Register read answer.
  output logic [15:0] RDATA,
  output logic RVALID,
  // Channel gains as linear factors.
  output acr_gains_t GAINS,
  // Digital output on the channel 2 positive input pin.
  output logic CH2_POSITIVE_INPUT_PIN_O,
  output logic CH2_POSITIVE_INPUT_PIN_OE,
  // Global chop control.
  output logic CHOP_SETTLING,
  output logic MEASURE_ENABLE,
  // Channel 0 controls.
  output logic signed [9:0] CH0_SAMPLE_PHASE_DELAY,
  output acr_input_sel_t CH0_INPUT_SELECT,
  output logic signed [23:0] CH0_OFFSET
);
  logic [15:0] words [`ACR_REG_COUNT];
  logic [15:0] rd_word;
  logic rd_pending;
  acr_chop_state_t chop_state;
  acr_chop_state_t next_chop_state;
  logic [16:0] chop_count;
  logic [16:0] next_chop_count;

  // Map a register address to a memory slot; used by both read and write paths.
  function automatic logic [2:0] addr_slot(input logic [5:0] a);
    case (a)
      `ACR_ADDR_GAIN: addr_slot = 3'h0;
      `ACR_ADDR_GLOBAL_CONFIG: addr_slot = 3'h1;
      `ACR_ADDR_CH0_CONFIG: addr_slot = 3'h2;
      `ACR_ADDR_CH0_OFS_HIGH: addr_slot = 3'h3;
      `ACR_ADDR_CH0_OFS_LOW: addr_slot = 3'h4;
      default: addr_slot = 3'h7;
    endcase
  endfunction

  // Power-of-two gain decode shared by the three channels.
  function automatic logic [7:0] gain_of(input logic [2:0] code);
    gain_of = 8'h01 << code;
  endfunction

  // Write masks keep read-only reserved bits at zero whatever the host sends.
  wire [2:0] wr_slot = addr_slot(REQ.addr);
  wire [2:0] rd_slot = addr_slot(REQ.rd_en ? REQ.addr : 6'h00);
  wire wr_hit = REQ.wr_en && (wr_slot != 3'h7);
  wire [15:0] wr_mask = (wr_slot == 3'h2) ? `ACR_MASK_CH0_CONFIG :
                        (wr_slot == 3'h4) ? `ACR_MASK_CH0_OFS_LOW : `ACR_MASK_FULL;

  acr_regfile u_regfile (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .wr_en(wr_hit),
    .wr_slot(wr_slot),
    .wr_data(REQ.wdata),
    .wr_mask(wr_mask),
    .rd_slot(rd_slot),
    .rd_data(rd_word),
    .words(words)
  );

  // Field decode of the stored words.
  wire [15:0] gain_w = words[0];
  wire [15:0] cfg_w = words[1];
  wire [15:0] ch0_w = words[2];
  wire [15:0] ofs_hi_w = words[3];
  wire [15:0] ofs_lo_w = words[4];
  wire dout_en = cfg_w[`ACR_DOUT_EN_BIT];
  wire dout_val = cfg_w[`ACR_DOUT_VAL_BIT];
  wire chop_en = cfg_w[`ACR_CHOP_EN_BIT];
  wire [3:0] chop_code = cfg_w[`ACR_CHOP_MSB:`ACR_CHOP_LSB];
  wire [16:0] chop_len = 17'h00002 << chop_code;
  wire [23:0] ofs_full = {ofs_hi_w, ofs_lo_w[15:8]};
  acr_gains_t next_gains;
  assign next_gains.ch2_gain = gain_of(gain_w[`ACR_G2_MSB:`ACR_G2_LSB]);
  assign next_gains.ch1_gain = gain_of(gain_w[`ACR_G1_MSB:`ACR_G1_LSB]);
  assign next_gains.ch0_gain = gain_of(gain_w[`ACR_G0_MSB:`ACR_G0_LSB]);

  // Global-chop settling: after enable, hold measurement off for the coded delay.
  // A code change mid-settle is not restarted; the new length applies next time.
  always_comb begin
    next_chop_state = chop_state;
    next_chop_count = chop_count;
    case (chop_state)
      ACR_CHOP_IDLE: begin
        if (chop_en) begin
          next_chop_state = ACR_CHOP_SETTLE;
          next_chop_count = chop_len - 17'h00001;
        end
      end
      ACR_CHOP_SETTLE: begin
        if (!chop_en) begin
          next_chop_state = ACR_CHOP_IDLE;
        end else if (chop_count == 17'h00000) begin
          next_chop_state = ACR_CHOP_MEASURE;
        end else begin
          next_chop_count = chop_count - 17'h00001;
        end
      end
      ACR_CHOP_MEASURE: begin
        if (!chop_en) begin
          next_chop_state = ACR_CHOP_IDLE;
        end
      end
      default: next_chop_state = ACR_CHOP_IDLE;
    endcase
  end

  // Chop state register.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      chop_state <= ACR_CHOP_IDLE;
      chop_count <= 17'h00000;
    end else begin
      chop_state <= next_chop_state;
      chop_count <= next_chop_count;
    end
  end

  // Read answer follows the registered memory read by one cycle of valid.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rd_pending <= 1'b0;
    end else begin
      rd_pending <= REQ.rd_en;
    end
  end

  // Outputs all come from flops; the read word is already registered in the memory.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      RDATA <= 16'h0000;
      RVALID <= 1'b0;
      GAINS <= '{ch2_gain: 8'h01, ch1_gain: 8'h01, ch0_gain: 8'h01};
      CH2_POSITIVE_INPUT_PIN_O <= 1'b0;
      CH2_POSITIVE_INPUT_PIN_OE <= 1'b0;
      CHOP_SETTLING <= 1'b0;
      MEASURE_ENABLE <= 1'b1;
      CH0_SAMPLE_PHASE_DELAY <= 10'sh000;
      CH0_INPUT_SELECT <= ACR_IN_EXTERNAL;
      CH0_OFFSET <= 24'sh000000;
    end else begin
      RDATA <= rd_pending ? rd_word : 16'h0000;
      RVALID <= rd_pending;
      GAINS <= next_gains;
      CH2_POSITIVE_INPUT_PIN_OE <= dout_en;
      CH2_POSITIVE_INPUT_PIN_O <= dout_en & dout_val;
      CHOP_SETTLING <= (next_chop_state == ACR_CHOP_SETTLE);
      MEASURE_ENABLE <= (next_chop_state != ACR_CHOP_SETTLE);
      CH0_SAMPLE_PHASE_DELAY <= signed'(ch0_w[`ACR_PHASE_MSB:`ACR_PHASE_LSB]);
      CH0_INPUT_SELECT <= acr_input_sel_t'(ch0_w[`ACR_MUX_MSB:`ACR_MUX_LSB]);
      CH0_OFFSET <= signed'(ofs_full);
    end
  end

  // Checks that tie outputs to the stored configuration.
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  chk_ch2_gain_pow: assert property (##1 GAINS.ch2_gain == (8'h01 << $past(words[0][10:8])))
    else $error("Channel 2 gain does not match its code.");
  chk_ch1_gain_pow: assert property (##1 GAINS.ch1_gain == (8'h01 << $past(words[0][6:4])))
    else $error("Channel 1 gain does not match its code.");
  chk_ch0_gain_pow: assert property (##1 GAINS.ch0_gain == (8'h01 << $past(words[0][2:0])))
    else $error("Channel 0 gain does not match its code.");
  chk_dout_enable: assert property ($rose(words[1][14]) |=> CH2_POSITIVE_INPUT_PIN_OE)
    else $error("Digital output not enabled after the enable bit was set.");
  chk_dout_level: assert property (CH2_POSITIVE_INPUT_PIN_OE |-> CH2_POSITIVE_INPUT_PIN_O == $past(words[1][13]))
    else $error("Digital output level differs from the value bit.");
  chk_chop_settle_len: assert property (
      chop_state == ACR_CHOP_IDLE && chop_en && chop_code == 4'h0 ##1 chop_en [*2]
      |=> chop_state == ACR_CHOP_MEASURE)
    else $error("Shortest chop settling did not last two cycles.");
  chk_chop_blocks_meas: assert property (chop_state == ACR_CHOP_SETTLE |-> !MEASURE_ENABLE)
    else $error("Measurement enabled while settling.");
  chk_phase_field: assert property (##1 CH0_SAMPLE_PHASE_DELAY == $past(words[2][15:6]))
    else $error("Phase delay does not follow its field.");
  chk_input_sel: assert property (##1 CH0_INPUT_SELECT == $past(words[2][1:0]))
    else $error("Channel 0 input select does not follow its field.");
  chk_offset_upper: assert property (##1 CH0_OFFSET[23:8] == $past(words[3]))
    else $error("Offset upper bits wrong.");
  chk_offset_lower: assert property (##1 CH0_OFFSET[7:0] == $past(words[4][15:8]))
    else $error("Offset lower bits wrong.");
  chk_reserved_zero: assert property (words[4][7:0] == 8'h00 && words[2][5:2] == 4'h0)
    else $error("Read-only reserved bits are not zero.");

  cov_chop_measure: cover property (chop_state == ACR_CHOP_SETTLE ##1 chop_state == ACR_CHOP_MEASURE);
  cov_dout_high: cover property (CH2_POSITIVE_INPUT_PIN_OE && CH2_POSITIVE_INPUT_PIN_O);
  cov_read_back: cover property (REQ.rd_en ##2 RVALID);
endmodule

// ### rtl/acr_map.svh
// Register offsets, field positions, reset values and write masks for the ADC config bank.
// Assumes a 16-bit register word indexed by a 6-bit register address.
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH
`define ACR_ADDR_GAIN 6'h04
`define ACR_ADDR_GLOBAL_CONFIG 6'h06
`define ACR_ADDR_CH0_CONFIG 6'h09
`define ACR_ADDR_CH0_OFS_HIGH 6'h0A
`define ACR_ADDR_CH0_OFS_LOW 6'h0B
`define ACR_RESET_GAIN 16'h0000
`define ACR_RESET_GLOBAL_CONFIG 16'h0600
`define ACR_RESET_CH0_CONFIG 16'h0000
`define ACR_RESET_CH0_OFS 16'h0000
`define ACR_RESET_CHOP_CODE 4'h3
`define ACR_MASK_CH0_CONFIG 16'hFFC3
`define ACR_MASK_CH0_OFS_LOW 16'hFF00
`define ACR_MASK_FULL 16'hFFFF
`define ACR_DOUT_EN_BIT 14
`define ACR_DOUT_VAL_BIT 13
`define ACR_CHOP_MSB 12
`define ACR_CHOP_LSB 9
`define ACR_CHOP_EN_BIT 8
`define ACR_PHASE_MSB 15
`define ACR_PHASE_LSB 6
`define ACR_MUX_MSB 1
`define ACR_MUX_LSB 0
`define ACR_G2_MSB 10
`define ACR_G2_LSB 8
`define ACR_G1_MSB 6
`define ACR_G1_LSB 4
`define ACR_G0_MSB 2
`define ACR_G0_LSB 0
`define ACR_REG_COUNT 5
`endif

// ### rtl/acr_pkg.sv
// Types shared by the ADC configuration register bank.
// Assumes the map header supplies all numeric constants.
package acr_pkg;
  typedef enum logic [1:0] {
    ACR_IN_EXTERNAL,
    ACR_IN_SHORTED,
    ACR_IN_DC_DIAG,
    ACR_IN_AC_DIAG
  } acr_input_sel_t;

  typedef enum logic [1:0] {
    ACR_CHOP_IDLE,
    ACR_CHOP_SETTLE,
    ACR_CHOP_MEASURE
  } acr_chop_state_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [5:0] addr;
    logic [15:0] wdata;
  } acr_req_t;

  typedef struct packed {
    logic [7:0] ch2_gain;
    logic [7:0] ch1_gain;
    logic [7:0] ch0_gain;
  } acr_gains_t;
endpackage

// ### rtl/acr_regfile.sv
// Small register memory holding the five configuration words of the bank.
// Assumes the caller gives a slot index already decoded and a per-word write mask.
`timescale 1ns/100ps
`include "acr_map.svh"
module acr_regfile
  import acr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Write side.
  input wire logic wr_en,
  input wire logic [2:0] wr_slot,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] wr_mask,
  // Read side, registered.
  input wire logic [2:0] rd_slot,
  output logic [15:0] rd_data,
  // Whole contents for the decode logic.
  output logic [15:0] words [`ACR_REG_COUNT]
);
  // Reset values per slot; reserved bits are masked so they stay zero.
  function automatic logic [15:0] slot_reset(input int s);
    case (s)
      1: slot_reset = `ACR_RESET_GLOBAL_CONFIG;
      default: slot_reset = 16'h0000;
    endcase
  endfunction

  // Each word is its own generate lane so write masking stays per word.
  for (genvar i = 0; i < `ACR_REG_COUNT; i++) begin : g_word
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        words[i] <= slot_reset(i);
      end else if (wr_en && wr_slot == 3'(i)) begin
        words[i] <= wr_data & wr_mask;
      end
    end
  end

  // Registered read so the answer timing is fixed at one cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= (rd_slot < 3'(`ACR_REG_COUNT)) ? words[rd_slot] : 16'h0000;
    end
  end
endmodule

// ### tb/acr_host_model.sv
// Host model that issues register requests to the configuration bank.
// Assumes the bank takes a request on each rising clk edge and answers reads later.
`timescale 1ns/100ps
module acr_host_model
  import acr_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Request toward the bank and its answer.
  output acr_req_t req,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  initial begin
    req = '0;
  end

  // Writes one word for one cycle, clearing the reserved writable bits first.
  // Idle fields show the inverse of the last value so that stale data never looks valid.
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic [15:0] keep);
    @(posedge clk);
    req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d & keep};
    @(posedge clk);
    req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~(d & keep)};
  endtask

  // Reads one word; the answer wait is bounded so a silent bank cannot hang the run.
  task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk);
    req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: 16'hFFFF};
    ok = 1'b0;
    d = 16'h0000;
    for (int n = 0; n < 4 && ok == 1'b0; n++) begin
      @(posedge clk);
      #1;
      if (rvalid === 1'b1) begin
        ok = 1'b1;
        d = rdata;
      end
    end
  endtask
endmodule

// ### tb/acr_config_regs_tb_top.sv
// Self-checking bench for the ADC configuration register bank.
// Assumes the host model issues all register traffic at the rising clock edge.
`timescale 1ns/100ps
`include "acr_map.svh"
module acr_config_regs_tb_top
  import acr_pkg::*;
;
  logic ref_clk;
  logic rst_n;
  acr_req_t req;
  logic [15:0] rdata;
  logic rvalid;
  acr_gains_t gains;
  logic pin_o;
  logic pin_oe;
  logic settling;
  logic meas;
  logic signed [9:0] phase;
  acr_input_sel_t sel;
  logic signed [23:0] ofs;
  int n_errors;
  int checks;

  // Free-running 125 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  acr_config_regs DUT (.REF_CLK(ref_clk), .RST_N(rst_n), .REQ(req), .RDATA(rdata),
    .RVALID(rvalid), .GAINS(gains), .CH2_POSITIVE_INPUT_PIN_O(pin_o),
    .CH2_POSITIVE_INPUT_PIN_OE(pin_oe), .CHOP_SETTLING(settling), .MEASURE_ENABLE(meas),
    .CH0_SAMPLE_PHASE_DELAY(phase), .CH0_INPUT_SELECT(sel), .CH0_OFFSET(ofs));
  acr_host_model host (.clk(ref_clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  // Compares with case equality so an unknown never passes.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // A read must answer and carry the expected word.
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    logic ok;
    host.rd(a, d, ok);
    chk({15'h0000, ok, d}, {15'h0000, 1'b1, exp}, what);
  endtask

  // Decoded outputs follow a write two edges later, so three edges is safe.
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic test_reset();
    rd_chk(`ACR_ADDR_GAIN, 16'h0000, "gain reset");
    rd_chk(`ACR_ADDR_GLOBAL_CONFIG, 16'h0600, "config reset");
    rd_chk(`ACR_ADDR_CH0_CONFIG, 16'h0000, "ch0 config reset");
    rd_chk(`ACR_ADDR_CH0_OFS_HIGH, 16'h0000, "offset high reset");
    rd_chk(`ACR_ADDR_CH0_OFS_LOW, 16'h0000, "offset low reset");
    chk({8'h00, gains}, 32'h010101, "gains at reset");
    chk({pin_oe, meas, settling}, 32'h2, "pins at reset");
  endtask

  // Every code on every channel, with the channels kept apart.
  task automatic test_gains();
    logic [15:0] w;
    logic [2:0] c2;
    logic [2:0] c1;
    logic [2:0] c0;
    for (int c = 0; c < 8; c++) begin
      c2 = 3'(c);
      c1 = 3'(7 - c);
      c0 = 3'(c + 3);
      w = {5'h00, c2, 1'b0, c1, 1'b0, c0};
      host.wr(`ACR_ADDR_GAIN, w, 16'h0777);
      settle();
      chk({8'h00, gains}, {8'h00, 8'h01 << c2, 8'h01 << c1, 8'h01 << c0}, "gain");
      rd_chk(`ACR_ADDR_GAIN, w, "gain readback");
    end
  endtask

  task automatic test_dout();
    for (int v = 0; v < 2; v++) begin
      host.wr(`ACR_ADDR_GLOBAL_CONFIG, 16'hC600 | (16'(v) << 13), 16'h7F00);
      settle();
      chk({30'h0, pin_oe, pin_o}, {30'h0, 1'b1, 1'(v)}, "digital out");
    end
    host.wr(`ACR_ADDR_GLOBAL_CONFIG, 16'h2600, 16'h7F00);
    settle();
    chk({30'h0, pin_oe, pin_o}, 32'h0, "digital out off");
  endtask

  // Writes a config word that enables chop and counts the cycles with settling high.
  task automatic count_settle(input logic [15:0] w, output int high);
    high = 0;
    host.wr(`ACR_ADDR_GLOBAL_CONFIG, w, 16'h7F00);
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      if (settling === 1'b1) begin
        high++;
      end
    end
  endtask

  // Code 2 settles 8 cycles and code 0 two; chop is cleared between runs because
  // a code change alone does not restart settling. A long code is then aborted.
  task automatic test_chop();
    int high;
    count_settle(16'h0500, high);
    chk(32'(high), 32'h8, "settle length");
    chk({settling, meas}, 32'h1, "measuring");
    host.wr(`ACR_ADDR_GLOBAL_CONFIG, 16'h0000, 16'h7F00);
    count_settle(16'h0100, high);
    chk(32'(high), 32'h2, "shortest settle length");
    chk({settling, meas}, 32'h1, "measuring after short settle");
    host.wr(`ACR_ADDR_GLOBAL_CONFIG, 16'h1E00, 16'h7F00);
    host.wr(`ACR_ADDR_GLOBAL_CONFIG, 16'h1F00, 16'h7F00);
    settle();
    chk({settling, meas}, 32'h2, "long settle");
    host.wr(`ACR_ADDR_GLOBAL_CONFIG, 16'h1E00, 16'h7F00);
    settle();
    chk({settling, meas}, 32'h1, "chop abort");
  endtask

  // Extreme phase values with every selector code; read-only bits are written as ones.
  task automatic test_ch0_config();
    logic [15:0] w;
    logic [9:0] ph;
    for (int m = 0; m < 4; m++) begin
      ph = m[0] ? 10'h1FF : 10'h200;
      w = {ph, 4'hF, 2'(m)};
      host.wr(`ACR_ADDR_CH0_CONFIG, w, 16'hFFFF);
      settle();
      chk({20'h00000, phase, sel}, {20'h00000, ph, 2'(m)}, "ch0 config");
      rd_chk(`ACR_ADDR_CH0_CONFIG, w & 16'hFFC3, "ch0 readback");
    end
  endtask

  task automatic test_offset();
    host.wr(`ACR_ADDR_CH0_OFS_HIGH, 16'h8123, 16'hFFFF);
    settle();
    chk({8'h00, ofs}, 32'h812300, "offset upper");
    host.wr(`ACR_ADDR_CH0_OFS_LOW, 16'hA5FF, 16'hFFFF);
    settle();
    chk({8'h00, ofs}, 32'h8123A5, "offset full");
    rd_chk(`ACR_ADDR_CH0_OFS_LOW, 16'hA500, "offset low readback");
    rd_chk(6'h3F, 16'h0000, "unmapped read");
  endtask

  task automatic print_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Reset for four cycles, then run each scenario once.
  initial begin
    n_errors = 0;
    checks = 0;
    rst_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_reset();
    test_gains();
    test_dout();
    test_chop();
    test_ch0_config();
    test_offset();
    print_verdict();
  end
endmodule
